// file: src/psam_top.sv
// Added by the designer: the Wishbone interface to the registers and the address map.
`include "psam_params.svh"

// Summary of operation
// - 24-bit program, 16-bit data, alignment kept
// - Table page is 8 bits, 32K words
// - Table address is page above EA
// - Page MSb selects configuration memory
// - Table access reaches every byte, upper too
// - Visibility page is 8 bits, 16K words
// - EA MSb set: page above EA[14:0]
// - Remapped accesses stay in user memory
// - Remapped window is read-only
// - Remapped read returns low word only
// - Priority MSb joins status bits 7:5
// - Unimplemented core control bits read zero
// - EA bit 15 unused; page bit 0 instead
module psam_top (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic acc_req_i,
    input wire logic acc_tbl_i,
    input wire logic acc_we_i,
    input wire logic acc_byte_i,
    input wire logic acc_hi_i,
    input wire logic [15:0] acc_ea_i,
    input wire logic [15:0] acc_wdata_i,
    output logic acc_ready_o,
    output logic acc_done_o,
    output logic [15:0] acc_rdata_o,
    output logic [23:0] pm_addr_o,
    output logic pm_cfg_o,
    output logic pm_rd_o,
    output logic pm_wr_o,
    output logic [2:0] pm_be_o,
    output logic [23:0] pm_wdata_o,
    input wire logic [23:0] pm_rdata_i,
    output logic [15:0] ds_addr_o,
    output logic ds_rd_o,
    output logic ds_wr_o,
    output logic [1:0] ds_be_o,
    output logic [15:0] ds_wdata_o,
    input wire logic [15:0] ds_rdata_i,
    input wire logic [15:0] status_word_i,
    input wire logic prio_set_i,
    output logic [3:0] cpu_prio_o,
    output logic vis_en_o
);
    import psam_pkg::*;

    psam_top_st_t st_ff;
    psam_top_st_t nxt_st;

    logic wb_req;
    logic wb_commit;
    logic cc_wr;
    logic cc_vis_en;
    logic cc_prio_msb;
    logic [15:0] cc_value;
    logic take;
    logic is_remap;
    logic [31:0] rd_word;

    // Write lands on the edge where the master sees ack
    assign wb_req = wb_cyc_i && wb_stb_i;
    assign wb_commit = wb_req && st_ff.wb_ack && wb_we_i;
    assign cc_wr = wb_commit && (wb_adr_i == `PSAM_OFF_CORE_CTRL);

    psam_core_ctrl u_core_ctrl (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .wr_i(cc_wr),
        .be_i(wb_sel_i[1:0]),
        .wdata_i(wb_dat_i[15:0]),
        .prio_set_i(prio_set_i),
        .vis_en_o(cc_vis_en),
        .prio_msb_o(cc_prio_msb),
        .value_o(cc_value)
    );

    assign take = (st_ff.state == PSAM_IDLE) && acc_req_i;
    assign is_remap = !acc_tbl_i && cc_vis_en && acc_ea_i[`PSAM_EA_MSB];

    // Read mux; unmapped offsets answer with zero
    always_comb begin
        rd_word = 32'h0000_0000;
        if (wb_adr_i == `PSAM_OFF_TABLE_PAGE) begin
            rd_word[7:0] = st_ff.tpage;
        end else if (wb_adr_i == `PSAM_OFF_VIS_PAGE) begin
            rd_word[7:0] = st_ff.vpage;
        end else if (wb_adr_i == `PSAM_OFF_CORE_CTRL) begin
            rd_word[15:0] = cc_value;
        end else if (wb_adr_i == `PSAM_OFF_STATUS) begin
            rd_word[`PSAM_ST_BLOCKED_BIT] = st_ff.blocked;
            rd_word[`PSAM_ST_PRIO_LSB +: 4] = st_ff.cpu_prio;
        end
    end

    always_comb begin
        nxt_st = st_ff;

        // Bus slave: one wait state, ack for exactly one cycle
        nxt_st.wb_ack = wb_req && !st_ff.wb_ack;
        nxt_st.wb_dat = (wb_req && !st_ff.wb_ack) ? rd_word : 32'h0000_0000;
        if (wb_commit && wb_sel_i[0]) begin
            if (wb_adr_i == `PSAM_OFF_TABLE_PAGE) begin
                nxt_st.tpage = wb_dat_i[7:0];
            end else if (wb_adr_i == `PSAM_OFF_VIS_PAGE) begin
                nxt_st.vpage = wb_dat_i[7:0];
            end else if (wb_adr_i == `PSAM_OFF_STATUS) begin
                if (wb_dat_i[`PSAM_ST_BLOCKED_BIT]) begin
                    nxt_st.blocked = 1'b0;
                end
            end
        end

        nxt_st.cpu_prio = {cc_prio_msb, status_word_i[7:5]};

        case (st_ff.state)
            PSAM_IDLE: begin
                nxt_st.done = 1'b0;
                if (take) begin
                    nxt_st.state = PSAM_ISSUE;
                    nxt_st.rdy = 1'b0;
                    nxt_st.hi = acc_hi_i;
                    nxt_st.byte_mode = acc_byte_i;
                    nxt_st.ea0 = acc_ea_i[0];
                    if (acc_tbl_i) begin
                        nxt_st.path = PSAM_P_TABLE;
                        // Page above the whole EA keeps word alignment
                        nxt_st.pm_addr = {st_ff.tpage, acc_ea_i};
                        nxt_st.pm_cfg = st_ff.tpage[7];
                        nxt_st.pm_rd = !acc_we_i;
                        nxt_st.pm_wr = acc_we_i;
                        if (acc_hi_i) begin
                            nxt_st.pm_be = `PSAM_BE_UPPER;
                        end else if (acc_byte_i) begin
                            nxt_st.pm_be = acc_ea_i[0] ? `PSAM_BE_MID : `PSAM_BE_LOW;
                        end else begin
                            nxt_st.pm_be = `PSAM_BE_WORD;
                        end
                        nxt_st.pm_wdata[23:16] = acc_wdata_i[7:0];
                        nxt_st.pm_wdata[15:0] = (acc_byte_i && acc_ea_i[0]) ?
                            {acc_wdata_i[7:0], 8'h00} : acc_wdata_i;
                    end else if (is_remap) begin
                        nxt_st.path = PSAM_P_REMAP;
                        // EA bit 15 dropped; page bit 0 lands there
                        nxt_st.pm_addr = {1'b0, st_ff.vpage, acc_ea_i[14:0]};
                        nxt_st.pm_cfg = 1'b0;
                        nxt_st.pm_rd = !acc_we_i;
                        nxt_st.pm_wr = 1'b0;
                        nxt_st.pm_be = `PSAM_BE_WORD;
                        nxt_st.pm_wdata = 24'h00_0000;
                        if (acc_we_i) begin
                            nxt_st.blocked = 1'b1;
                        end
                    end else begin
                        nxt_st.path = PSAM_P_DATA;
                        nxt_st.ds_addr = acc_ea_i;
                        nxt_st.ds_rd = !acc_we_i;
                        nxt_st.ds_wr = acc_we_i;
                        if (acc_byte_i) begin
                            nxt_st.ds_be = acc_ea_i[0] ? 2'h2 : 2'h1;
                        end else begin
                            nxt_st.ds_be = 2'h3;
                        end
                        nxt_st.ds_wdata = (acc_byte_i && acc_ea_i[0]) ?
                            {acc_wdata_i[7:0], 8'h00} : acc_wdata_i;
                    end
                end
            end
            PSAM_ISSUE: begin
                nxt_st.state = PSAM_RETURN;
                nxt_st.done = 1'b1;
                nxt_st.pm_rd = 1'b0;
                nxt_st.pm_wr = 1'b0;
                nxt_st.ds_rd = 1'b0;
                nxt_st.ds_wr = 1'b0;
                case (st_ff.path)
                    PSAM_P_TABLE: begin
                        if (st_ff.hi) begin
                            nxt_st.rdata = {8'h00, pm_rdata_i[23:16]};
                        end else if (st_ff.byte_mode) begin
                            nxt_st.rdata = st_ff.ea0 ?
                                {8'h00, pm_rdata_i[15:8]} : {8'h00, pm_rdata_i[7:0]};
                        end else begin
                            nxt_st.rdata = pm_rdata_i[15:0];
                        end
                    end
                    PSAM_P_REMAP: begin
                        // Upper byte never reaches the data side
                        if (st_ff.byte_mode) begin
                            nxt_st.rdata = st_ff.ea0 ?
                                {8'h00, pm_rdata_i[15:8]} : {8'h00, pm_rdata_i[7:0]};
                        end else begin
                            nxt_st.rdata = pm_rdata_i[15:0];
                        end
                    end
                    default: begin
                        if (st_ff.byte_mode) begin
                            nxt_st.rdata = st_ff.ea0 ?
                                {8'h00, ds_rdata_i[15:8]} : {8'h00, ds_rdata_i[7:0]};
                        end else begin
                            nxt_st.rdata = ds_rdata_i;
                        end
                    end
                endcase
            end
            PSAM_RETURN: begin
                nxt_st.state = PSAM_IDLE;
                nxt_st.done = 1'b0;
                nxt_st.rdy = 1'b1;
            end
            default: begin
                nxt_st.state = PSAM_IDLE;
                nxt_st.rdy = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_ff <= '0;
            st_ff.rdy <= 1'b1;
            st_ff.tpage <= `PSAM_PAGE_RESET;
            st_ff.vpage <= `PSAM_PAGE_RESET;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign wb_dat_o = st_ff.wb_dat;
    assign wb_ack_o = st_ff.wb_ack;
    assign acc_ready_o = st_ff.rdy;
    assign acc_done_o = st_ff.done;
    assign acc_rdata_o = st_ff.rdata;
    assign pm_addr_o = st_ff.pm_addr;
    assign pm_cfg_o = st_ff.pm_cfg;
    assign pm_rd_o = st_ff.pm_rd;
    assign pm_wr_o = st_ff.pm_wr;
    assign pm_be_o = st_ff.pm_be;
    assign pm_wdata_o = st_ff.pm_wdata;
    assign ds_addr_o = st_ff.ds_addr;
    assign ds_rd_o = st_ff.ds_rd;
    assign ds_wr_o = st_ff.ds_wr;
    assign ds_be_o = st_ff.ds_be;
    assign ds_wdata_o = st_ff.ds_wdata;
    assign cpu_prio_o = st_ff.cpu_prio;
    assign vis_en_o = cc_vis_en;

    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    chk_table_addr_form: assert property (
        take && acc_tbl_i |=> pm_addr_o == {$past(st_ff.tpage), $past(acc_ea_i)})
        else $error("table address not page above EA");
    chk_config_select: assert property (
        take && acc_tbl_i |=> pm_cfg_o == $past(st_ff.tpage[7]) && pm_cfg_o == pm_addr_o[23])
        else $error("config select does not follow page MSb");
    chk_remap_addr_form: assert property (
        take && is_remap |=> pm_addr_o[14:0] == $past(acc_ea_i[14:0])
            && pm_addr_o[22:15] == $past(st_ff.vpage))
        else $error("remap address malformed");
    chk_remap_user_only: assert property (
        st_ff.path == PSAM_P_REMAP && pm_rd_o |-> !pm_cfg_o && !pm_addr_o[23])
        else $error("remap reached configuration memory");
    chk_remap_no_write: assert property (
        take && is_remap && acc_we_i |=> !pm_wr_o && !ds_wr_o ##1 st_ff.blocked)
        else $error("remap write reached memory or was not flagged");
    chk_remap_low_word: assert property (
        st_ff.state == PSAM_ISSUE && st_ff.path == PSAM_P_REMAP && !st_ff.byte_mode
            |=> acc_done_o && acc_rdata_o == $past(pm_rdata_i[15:0]))
        else $error("remap read not low word");
    chk_upper_byte_read: assert property (
        st_ff.state == PSAM_ISSUE && st_ff.path == PSAM_P_TABLE && st_ff.hi
            |=> acc_rdata_o == {8'h00, $past(pm_rdata_i[23:16])})
        else $error("upper byte read wrong");
    chk_data_route: assert property (
        take && !acc_tbl_i && (!cc_vis_en || !acc_ea_i[15])
            |=> !pm_rd_o && !pm_wr_o && ds_addr_o == $past(acc_ea_i))
        else $error("plain data access went to program memory");
    chk_prio_level: assert property (
        ##1 cpu_prio_o == {$past(cc_prio_msb), $past(status_word_i[7:5])})
        else $error("priority level not assembled");
    chk_access_timing: assert property (
        take |=> !acc_ready_o ##1 acc_done_o ##1 acc_ready_o && !acc_done_o)
        else $error("access sequence timing wrong");
    chk_wb_ack_pulse: assert property (
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");

    cov_table_write_upper: cover property (take && acc_tbl_i && acc_we_i && acc_hi_i);
    cov_config_read: cover property (take && acc_tbl_i && st_ff.tpage[7] && !acc_we_i);
    cov_remap_read: cover property (take && is_remap && !acc_we_i);
    cov_remap_blocked: cover property (take && is_remap && acc_we_i);
endmodule : psam_top

// file: src/psam_params.svh
`ifndef PSAM_PARAMS_SVH
`define PSAM_PARAMS_SVH

// Register byte offsets on the bus
`define PSAM_OFF_TABLE_PAGE 8'h00
`define PSAM_OFF_VIS_PAGE 8'h04
`define PSAM_OFF_CORE_CTRL 8'h08
`define PSAM_OFF_STATUS 8'h0c

// Reset values
`define PSAM_PAGE_RESET 8'h00
`define PSAM_CC_RESET 16'h0000

// Core control field positions
`define PSAM_CC_VIS_BIT 2
`define PSAM_CC_PRIO_BIT 3

// Status register field positions
`define PSAM_ST_BLOCKED_BIT 0
`define PSAM_ST_PRIO_LSB 4

// Address geometry
`define PSAM_EA_MSB 15
`define PSAM_PM_CFG_BIT 23
`define PSAM_PM_WIDTH 24
`define PSAM_DS_WIDTH 16

// Program memory byte lane enables
`define PSAM_BE_LOW 3'h1
`define PSAM_BE_MID 3'h2
`define PSAM_BE_WORD 3'h3
`define PSAM_BE_UPPER 3'h4

`endif

// file: src/psam_pkg.sv
package psam_pkg;

    // Gray sequence idle -> issue -> return
    typedef enum logic [1:0] {
        PSAM_IDLE = 2'b00,
        PSAM_ISSUE = 2'b01,
        PSAM_RETURN = 2'b11
    } psam_state_t;

    typedef enum logic [1:0] {
        PSAM_P_DATA = 2'h0,
        PSAM_P_TABLE = 2'h1,
        PSAM_P_REMAP = 2'h2
    } psam_path_t;

    typedef struct packed {
        logic vis_en;
        logic prio_msb;
    } psam_cc_st_t;

    typedef struct packed {
        psam_state_t state;
        psam_path_t path;
        logic rdy;
        logic done;
        logic hi;
        logic byte_mode;
        logic ea0;
        logic [15:0] rdata;
        logic wb_ack;
        logic [31:0] wb_dat;
        logic [7:0] tpage;
        logic [7:0] vpage;
        logic blocked;
        logic [23:0] pm_addr;
        logic pm_cfg;
        logic pm_rd;
        logic pm_wr;
        logic [2:0] pm_be;
        logic [23:0] pm_wdata;
        logic [15:0] ds_addr;
        logic ds_rd;
        logic ds_wr;
        logic [1:0] ds_be;
        logic [15:0] ds_wdata;
        logic [3:0] cpu_prio;
    } psam_top_st_t;

endpackage : psam_pkg

// file: src/psam_core_ctrl.sv
`include "psam_params.svh"

module psam_core_ctrl (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wr_i,
    input wire logic [1:0] be_i,
    input wire logic [15:0] wdata_i,
    input wire logic prio_set_i,
    output logic vis_en_o,
    output logic prio_msb_o,
    output logic [15:0] value_o
);
    import psam_pkg::*;

    psam_cc_st_t st_ff;
    psam_cc_st_t nxt_st;

    always_comb begin
        nxt_st = st_ff;
        if (wr_i && be_i[0]) begin
            nxt_st.vis_en = wdata_i[`PSAM_CC_VIS_BIT];
            // Software may only clear the priority bit
            if (!wdata_i[`PSAM_CC_PRIO_BIT]) begin
                nxt_st.prio_msb = 1'b0;
            end
        end
        // Hardware set beats a same-cycle clear
        if (prio_set_i) begin
            nxt_st.prio_msb = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign vis_en_o = st_ff.vis_en;
    assign prio_msb_o = st_ff.prio_msb;

    always_comb begin
        value_o = `PSAM_CC_RESET;
        value_o[`PSAM_CC_VIS_BIT] = st_ff.vis_en;
        value_o[`PSAM_CC_PRIO_BIT] = st_ff.prio_msb;
    end

    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    chk_cc_vis_write: assert property (
        wr_i && be_i[0] |=> vis_en_o == $past(wdata_i[`PSAM_CC_VIS_BIT]))
        else $error("visibility enable did not follow write");
    chk_cc_set_wins: assert property (
        prio_set_i |=> prio_msb_o)
        else $error("priority bit set was lost");
    chk_cc_unimpl_zero: assert property (
        wr_i |=> value_o[15:4] == 12'h000 && value_o[1:0] == 2'h0)
        else $error("unimplemented core control bits not zero");
endmodule : psam_core_ctrl

// file: dv/psam_mem_model.sv
// Program and data memory seen by the mapper; combinational reads
module psam_mem_model (
    input wire logic clk_i,
    input wire logic [23:0] pm_addr_i,
    input wire logic pm_cfg_i,
    input wire logic pm_rd_i,
    input wire logic pm_wr_i,
    input wire logic [2:0] pm_be_i,
    input wire logic [23:0] pm_wdata_i,
    output logic [23:0] pm_rdata_o,
    input wire logic [15:0] ds_addr_i,
    input wire logic ds_rd_i,
    output logic [15:0] ds_rdata_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [23:0] pmem [logic [24:0]];
    logic [23:0] junk_ff = 24'h5a5a5a;
    logic [24:0] key;
    logic [23:0] word;
    always @(posedge clk_i) begin
        logic [23:0] merged;
        merged = word;
        junk_ff <= ~junk_ff + 24'h1;
        if (pm_wr_i) begin
            for (int l = 0; l < 3; l++) begin
                if (pm_be_i[l]) begin
                    merged[8*l+:8] = pm_wdata_i[8*l+:8];
                end
            end
            pmem[key] = merged;
        end
    end
    // Released buses show a changing pattern, never a stale word
    always @* begin
        key = {pm_cfg_i, pm_addr_i};
        word = pmem.exists(key) ? pmem[key] : {key[7:0] ^ 8'h3c, key[15:0]};
        pm_rdata_o = pm_rd_i ? word : junk_ff;
        ds_rdata_o = ds_rd_i ? (ds_addr_i ^ 16'hc3a5) : junk_ff[15:0];
    end
endmodule : psam_mem_model

// file: dv/psam_top_tb.sv
module psam_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import psam_pkg::*;
    logic clk_i = 0, rst_i = 1;
    logic wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, wb_ack_o;
    logic [7:0] wb_adr_i = 0;
    logic [3:0] wb_sel_i = 0;
    logic [31:0] wb_dat_i = 0, wb_dat_o, q;
    logic acc_req_i = 0, acc_tbl_i = 0, acc_we_i = 0, acc_byte_i = 0, acc_hi_i = 0;
    logic [15:0] acc_ea_i = 0, acc_wdata_i = 0, acc_rdata_o, ds_addr_o, ds_wdata_o;
    logic [15:0] ds_rdata_i, status_word_i = 0;
    logic acc_ready_o, acc_done_o, pm_cfg_o, pm_rd_o, pm_wr_o, ds_rd_o, ds_wr_o;
    logic [23:0] pm_addr_o, pm_wdata_o, pm_rdata_i;
    logic [2:0] pm_be_o;
    logic [1:0] ds_be_o;
    logic prio_set_i = 0, vis_en_o;
    logic [3:0] cpu_prio_o;
    int n_errors = 0, cmp_count = 0, seed = 96;
    logic [7:0] tpage = 0, vpage = 0;
    logic vis = 0, pmsb = 0, blocked = 0;

    psam_top dut (.*);
    psam_mem_model mem (.clk_i(clk_i), .pm_addr_i(pm_addr_o), .pm_cfg_i(pm_cfg_o),
        .pm_rd_i(pm_rd_o), .pm_wr_i(pm_wr_o), .pm_be_i(pm_be_o), .pm_wdata_i(pm_wdata_o),
        .pm_rdata_o(pm_rdata_i), .ds_addr_i(ds_addr_o), .ds_rd_i(ds_rd_o),
        .ds_rdata_o(ds_rdata_i));

    initial begin
        forever #5 clk_i = ~clk_i;
    end

    task automatic cmp_reg(string n, logic [31:0] e, logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask : cmp_reg

    task automatic cmp_acc(string n, logic [31:0] e, logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask : cmp_acc

    task automatic wb(logic we, logic [7:0] a, logic [31:0] d);
        @(posedge clk_i);
        wb_cyc_i <= 1;
        wb_stb_i <= 1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_sel_i <= 4'hf;
        wb_dat_i <= d;
        // Request stands until the edge that samples ack; a hang is the watchdog's
        do begin
            @(posedge clk_i);
        end while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        wb_cyc_i <= 0;
        wb_stb_i <= 0;
        wb_we_i <= 0;
    endtask : wb

    task automatic rd(logic [7:0] a, logic [31:0] e);
        wb(0, a, 0);
        cmp_reg("register", e, q);
    endtask : rd

    function automatic logic [31:0] st_exp();
        return {24'h0, pmsb, status_word_i[7:5], 3'h0, blocked};
    endfunction : st_exp

    task automatic acc(bit tbl, bit we, bit byt, bit hi, logic [15:0] ea, logic [15:0] wd);
        bit rm;
        logic [2:0] be;
        logic [5:0] ec;
        logic [15:0] er;
        logic [23:0] src, wl, m, pa;
        rm = !tbl && vis && ea[15];
        // A remapped read always fetches the whole low word
        be = rm ? 3'h3 : hi ? 3'h4 : byt ? (ea[0] ? 3'h2 : 3'h1) : 3'h3;
        m = {{8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
        // Byte data sits in the low byte and is copied to its lane
        wl = byt ? {3{wd[7:0]}} : {wd[7:0], wd};
        pa = tbl ? {tpage, ea} : {1'b0, vpage, ea[14:0]};
        ec = {tbl && tpage[7], !we, we, be};
        while (acc_ready_o !== 1'b1) begin
            @(negedge clk_i);
        end
        @(posedge clk_i);
        {acc_req_i, acc_tbl_i, acc_we_i, acc_byte_i, acc_hi_i} <= {1'b1, tbl, we, byt, hi};
        acc_ea_i <= ea;
        acc_wdata_i <= wd;
        @(posedge clk_i);
        acc_req_i <= 0;
        @(negedge clk_i);
        cmp_acc("ready_done", 0, {acc_ready_o, acc_done_o});
        if (rm && we) begin
            cmp_acc("blocked", 0, {pm_rd_o, pm_wr_o, ds_rd_o, ds_wr_o});
            blocked = 1;
        end else if (tbl || rm) begin
            cmp_acc("pm_addr", pa, pm_addr_o);
            cmp_acc("pm_ctl", ec, {pm_cfg_o, pm_rd_o, pm_wr_o, pm_be_o});
            cmp_acc("pm_ds_idle", 0, {ds_rd_o, ds_wr_o});
            if (we) cmp_acc("pm_wdata", wl & m, pm_wdata_o & m);
        end else begin
            cmp_acc("ds_addr", {ea, be[1:0]}, {ds_addr_o, ds_be_o});
            cmp_acc("ds_strobe", {!we, we, 2'b0}, {ds_rd_o, ds_wr_o, pm_rd_o, pm_wr_o});
            if (we) cmp_acc("ds_wdata", wl[15:0] & m[15:0], ds_wdata_o & m[15:0]);
        end
        src = (tbl || rm) ? pm_rdata_i : {8'h0, ds_rdata_i};
        er = hi ? src[23:16] : byt ? (ea[0] ? src[15:8] : src[7:0]) : src[15:0];
        @(negedge clk_i);
        cmp_acc("ready_done", 1, {acc_ready_o, acc_done_o});
        if (!we) cmp_acc("rdata", er, acc_rdata_o);
    endtask : acc

    task automatic report_and_stop();
        $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : report_and_stop

    initial begin
        // Whole run needs well under a thousand cycles
        #200000;
        n_errors++;
        report_and_stop();
    end

    initial begin
        repeat (20) @(posedge clk_i);
        rst_i <= 0;
        for (int i = 0; i < 5; i++) rd(8'(4 * i), 0);
        wb(1, 8'h08, 32'hffffffff);
        vis = 1;
        rd(8'h08, 32'h4);
        cmp_reg("vis_en", 1, vis_en_o);
        wb(1, 8'h10, 32'hffffffff);
        rd(8'h10, 0);
        status_word_i <= $random(seed);
        prio_set_i <= 1;
        @(posedge clk_i);
        prio_set_i <= 0;
        pmsb = 1;
        rd(8'h08, 32'hc);
        cmp_reg("cpu_prio", {pmsb, status_word_i[7:5]}, cpu_prio_o);
        rd(8'h0c, st_exp());
        wb(1, 8'h08, 32'h4);
        pmsb = 0;
        rd(8'h08, 32'h4);
        cmp_reg("cpu_prio", {pmsb, status_word_i[7:5]}, cpu_prio_o);
        tpage = 8'h80;
        wb(1, 8'h00, tpage);
        acc(1, 1, 0, 0, 16'h1234, 16'hbeef);
        acc(1, 1, 1, 1, 16'h1234, 16'h00a7);
        acc(1, 0, 1, 1, 16'h1234, 0);
        acc(1, 0, 0, 0, 16'h1234, 0);
        acc(0, 1, 0, 0, 16'h8001, 16'h5555);
        acc(0, 0, 0, 0, 16'h8001, 0);
        rd(8'h0c, st_exp());
        for (int k = 0; k < 64; k++) begin
            if (k % 8 == 0) begin
                tpage = $random(seed);
                vpage = $random(seed);
                vis = $random(seed);
                wb(1, 8'h08, {29'h0, vis, 2'h0});
                wb(1, 8'h00, tpage);
                wb(1, 8'h04, vpage);
                cmp_reg("vis_en", vis, vis_en_o);
            end
            q = $random(seed);
            acc(q[0], q[1], q[2], q[0] & q[3], q[31:16], $random(seed));
        end
        rd(8'h0c, st_exp());
        wb(1, 8'h0c, 32'h1);
        blocked = 0;
        rd(8'h0c, st_exp());
        report_and_stop();
    end
endmodule : psam_top_tb
